/* include/ramp_pkg.sv */
package ramp_pkg;

    // ------------
    // Timing
    // ------------
    localparam int CLK_HZ          = 100_000_000;
    localparam int TICK_MS         = 100;
    localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;

    // ------------
    // Register byte offsets
    // ------------
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_LEVEL_ONE = 8'h04;
    localparam logic [7:0] ADDR_LEVEL_TWO = 8'h08;
    localparam logic [7:0] ADDR_CEILING   = 8'h0c;
    localparam logic [7:0] ADDR_SS_OFFSET = 8'h10;
    localparam logic [7:0] ADDR_RATE      = 8'h14;
    localparam logic [7:0] ADDR_GAIN      = 8'h18;
    localparam logic [7:0] ADDR_BASE      = 8'h1c;
    localparam logic [7:0] ADDR_STATUS    = 8'h20;
    localparam logic [7:0] ADDR_LEVEL_NOW = 8'h24;
    localparam logic [7:0] ADDR_OUTPUT    = 8'h28;

    // ------------
    // Control and status register fields
    // ------------
    localparam int CTRL_DEC_LSB  = 0;
    localparam int CTRL_SRC1_LSB = 4;
    localparam int CTRL_SRC2_LSB = 8;
    localparam int STATUS_LOCK_BIT = 8;

    // ------------
    // Value limits and scales
    // ------------
    localparam logic signed [15:0] LEVEL_MIN  = -16'sd10000;
    localparam logic signed [15:0] LEVEL_MAX  = 16'sd20000;
    localparam logic signed [15:0] SS_MIN     = 16'sd0;
    localparam logic signed [15:0] SS_MAX     = 16'sd20000;
    localparam logic signed [15:0] RATE_MIN   = 16'sd1;
    localparam logic signed [15:0] RATE_MAX   = 16'sd10000;
    localparam logic signed [15:0] GAIN_MIN   = 16'sd0;
    localparam logic signed [15:0] GAIN_MAX   = 16'sd1000;
    localparam logic signed [15:0] BASE_MIN   = -16'sd10000;
    localparam logic signed [15:0] BASE_MAX   = 16'sd10000;
    localparam logic [31:0]        OUT_MAX    = 32'h0000_7fff;
    localparam logic [15:0]        GAIN_SCALE = 16'h0064;
    localparam logic [15:0]        RATE_DIV   = 16'h000a;

    // ------------
    // Reset values
    // ------------
    localparam logic signed [15:0] RST_LEVEL   = 16'sd0;
    localparam logic signed [15:0] RST_CEILING = 16'sd20000;
    localparam logic signed [15:0] RST_SS      = 16'sd0;
    localparam logic signed [15:0] RST_RATE    = 16'sd1;
    localparam logic signed [15:0] RST_GAIN    = 16'sd100;
    localparam logic signed [15:0] RST_BASE    = 16'sd0;

    // ------------
    // Types
    // ------------
    typedef struct packed {
        logic [3:0]         src_two;
        logic [3:0]         src_one;
        logic [1:0]         decimals;
        logic signed [15:0] level_one;
        logic signed [15:0] level_two;
        logic signed [15:0] ceiling;
        logic signed [15:0] ss_offset;
        logic signed [15:0] rate;
        logic signed [15:0] gain;
        logic signed [15:0] base;
    } cfg_s;

    typedef enum logic [5:0] {
        ST_IDLE      = 6'b000001,
        ST_START     = 6'b000010,
        ST_RAMP      = 6'b000100,
        ST_STOP_RAMP = 6'b001000,
        ST_STOP_HOLD = 6'b010000,
        ST_LOCKED    = 6'b100000
    } ramp_state_e;

endpackage : ramp_pkg

/* logic/quotient_unit.sv */
module quotient_unit
    import ramp_pkg::*;
#(
    parameter int NUM_W = 32,
    parameter int DEN_W = 16
)
(
    // Clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             reset_n_in,
    // Request
    input  wire logic             start_in,
    input  wire logic [NUM_W-1:0] num_in,
    input  wire logic [DEN_W-1:0] den_in,
    // Result
    output logic                  busy_out,
    output logic                  done_out,
    output logic [NUM_W-1:0]      quot_out
);

    // ------------------------------------------------------------------
    // Restoring divider, one quotient bit per cycle
    // ------------------------------------------------------------------
    logic [NUM_W-1:0] quot_q, quot_d;
    logic [DEN_W:0]   rem_q, rem_d;
    logic [DEN_W-1:0] den_q, den_d;
    logic [7:0]       cnt_q, cnt_d;
    logic             busy_q, busy_d;
    logic             done_q, done_d;

    always_comb
    begin
        logic [DEN_W:0] shifted;
        shifted = '0;
        quot_d  = quot_q;
        rem_d   = rem_q;
        den_d   = den_q;
        cnt_d   = cnt_q;
        busy_d  = busy_q;
        done_d  = 1'b0;
        if (!busy_q && start_in)
        begin
            quot_d = num_in;
            rem_d  = '0;
            den_d  = den_in;
            cnt_d  = 8'(NUM_W);
            busy_d = 1'b1;
        end
        else if (busy_q)
        begin
            shifted = {rem_q[DEN_W-1:0], quot_q[NUM_W-1]};
            if (shifted >= {1'b0, den_q})
            begin
                rem_d  = shifted - {1'b0, den_q};
                quot_d = {quot_q[NUM_W-2:0], 1'b1};
            end
            else
            begin
                rem_d  = shifted;
                quot_d = {quot_q[NUM_W-2:0], 1'b0};
            end
            cnt_d = cnt_q - 8'h01;
            if (cnt_q == 8'h01)
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            quot_q <= '0;
            rem_q  <= '0;
            den_q  <= '0;
            cnt_q  <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            quot_q <= quot_d;
            rem_q  <= rem_d;
            den_q  <= den_d;
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy_out = busy_q;
    assign done_out = done_q;
    assign quot_out = quot_q;

endmodule : quotient_unit

/* logic/analog_level_ramp.sv */
// Notes on behaviour
// - Enable rise: start level 100 ms, then ramp (the design holds it two ticks, 200 ms, before the first step).
// - Enable fall: level to base offset at once.
// - Select low picks level one, high level two.
// - Select change ramps to new target at rate.
// - Stop rise: ramp down, hold 100 ms, base.
// - After stop, restart needs stop and enable low.
// - Levels, ceiling limited; level never exceeds ceiling.
// - Start/stop offset 0..20000, added to base.
// - Rate is 1..10000 steps per second.
// - Output is (level minus base) over gain.
// - Gain 0..10.00, base offset -10000..10000.
// - Level recomputed once per 100 ms tick.
// - Decimal places only affect display, not values.
// - Targets may come from another block's value.
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
module analog_level_ramp
    import ramp_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter int NUM_SRC     = 4
)
(
    // Clock and reset
    input  wire logic                    sys_clk_in,
    input  wire logic                    reset_n_in,
    // Wishbone slave
    input  wire logic                    wb_cyc_in,
    input  wire logic                    wb_stb_in,
    input  wire logic                    wb_we_in,
    input  wire logic [7:0]              wb_adr_in,
    input  wire logic [3:0]              wb_sel_in,
    input  wire logic [31:0]             wb_dat_in,
    output logic      [31:0]             wb_dat_out,
    output logic                         wb_ack_out,
    // Control inputs from neighbouring logic
    input  wire logic                    enable_in,
    input  wire logic                    level_select_in,
    input  wire logic                    decel_stop_in,
    input  wire logic [NUM_SRC-1:0][15:0] source_value_in,
    // Results
    output logic signed [15:0]           current_level_out,
    output logic [15:0]                  scaled_output_out,
    output logic                         ramp_active_out
);

    // ------------
    // Helpers
    // ------------
    function automatic logic signed [15:0] limit(
        input logic signed [15:0] v,
        input logic signed [15:0] lo,
        input logic signed [15:0] hi);
        limit = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : limit

    // Byte-lane merge of a 16-bit register, then range limiting.
    function automatic logic signed [15:0] lane_write(
        input logic signed [15:0] old,
        input logic signed [15:0] lo,
        input logic signed [15:0] hi);
        logic [15:0] v;
        v = old;
        if (wb_sel_in[0])
            v[7:0] = wb_dat_in[7:0];
        if (wb_sel_in[1])
            v[15:8] = wb_dat_in[15:8];
        lane_write = limit(v, lo, hi);
    endfunction : lane_write

    // Moves toward the target by step and lands exactly on it.
    function automatic logic signed [15:0] step_toward(
        input logic signed [15:0] cur,
        input logic signed [15:0] tgt,
        input logic [15:0]        step);
        logic signed [16:0] diff;
        diff = 17'(tgt) - 17'(cur);
        if (diff >= 0)
            step_toward = (diff <= $signed({1'b0, step})) ? tgt
                        : 16'(cur + $signed(step));
        else
            step_toward = (-diff <= $signed({1'b0, step})) ? tgt
                        : 16'(cur - $signed(step));
    endfunction : step_toward

    function automatic logic signed [15:0] pick_source(
        input logic [3:0]         blk,
        input logic signed [15:0] own);
        pick_source = own;
        if (blk != 4'h0 && 32'(blk) <= NUM_SRC)
            pick_source = source_value_in[blk - 4'h1];
    endfunction : pick_source

    // ------------
    // Register file and bus slave
    // ------------
    cfg_s        cfg_q, cfg_d;
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    ramp_state_e state_q, state_d;
    logic signed [15:0] level_q, level_d;
    logic [15:0] scaled_q, scaled_d;

    wire logic bus_req = wb_cyc_in && wb_stb_in && !ack_q;

    always_comb
    begin
        cfg_d   = cfg_q;
        ack_d   = bus_req;
        rdata_d = 32'h0000_0000;
        if (bus_req && wb_we_in)
        begin
            case (wb_adr_in)
                ADDR_CTRL:
                begin
                    if (wb_sel_in[0])
                    begin
                        // Display hint only; never used in arithmetic.
                        cfg_d.decimals = wb_dat_in[CTRL_DEC_LSB +: 2];
                        cfg_d.src_one  = wb_dat_in[CTRL_SRC1_LSB +: 4];
                    end
                    if (wb_sel_in[1])
                        cfg_d.src_two = wb_dat_in[CTRL_SRC2_LSB +: 4];
                end
                ADDR_LEVEL_ONE: cfg_d.level_one =
                    lane_write(cfg_q.level_one, LEVEL_MIN, LEVEL_MAX);
                ADDR_LEVEL_TWO: cfg_d.level_two =
                    lane_write(cfg_q.level_two, LEVEL_MIN, LEVEL_MAX);
                ADDR_CEILING: cfg_d.ceiling =
                    lane_write(cfg_q.ceiling, LEVEL_MIN, LEVEL_MAX);
                ADDR_SS_OFFSET: cfg_d.ss_offset =
                    lane_write(cfg_q.ss_offset, SS_MIN, SS_MAX);
                ADDR_RATE: cfg_d.rate =
                    lane_write(cfg_q.rate, RATE_MIN, RATE_MAX);
                ADDR_GAIN: cfg_d.gain =
                    lane_write(cfg_q.gain, GAIN_MIN, GAIN_MAX);
                ADDR_BASE: cfg_d.base =
                    lane_write(cfg_q.base, BASE_MIN, BASE_MAX);
                default: ;
            endcase
        end
        if (bus_req && !wb_we_in)
        begin
            case (wb_adr_in)
                ADDR_CTRL: rdata_d = {20'h00000, cfg_q.src_two,
                    cfg_q.src_one, 2'b00, cfg_q.decimals};
                ADDR_LEVEL_ONE: rdata_d = 32'(cfg_q.level_one);
                ADDR_LEVEL_TWO: rdata_d = 32'(cfg_q.level_two);
                ADDR_CEILING:   rdata_d = 32'(cfg_q.ceiling);
                ADDR_SS_OFFSET: rdata_d = 32'(cfg_q.ss_offset);
                ADDR_RATE:      rdata_d = 32'(cfg_q.rate);
                ADDR_GAIN:      rdata_d = 32'(cfg_q.gain);
                ADDR_BASE:      rdata_d = 32'(cfg_q.base);
                ADDR_STATUS:    rdata_d = {23'h000000,
                    state_q == ST_LOCKED, 2'b00, state_q};
                ADDR_LEVEL_NOW: rdata_d = 32'(level_q);
                ADDR_OUTPUT:    rdata_d = {16'h0000, scaled_q};
                default:        rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cfg_q   <= '{src_two: 4'h0, src_one: 4'h0, decimals: 2'b00,
                         level_one: RST_LEVEL, level_two: RST_LEVEL,
                         ceiling: RST_CEILING, ss_offset: RST_SS,
                         rate: RST_RATE, gain: RST_GAIN, base: RST_BASE};
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            cfg_q   <= cfg_d;
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------
    // Ramp sequencer
    // ------------
    logic [31:0] tick_cnt_q, tick_cnt_d;
    logic        active_q, active_d;
    logic [3:0]  frac_q, frac_d;
    logic        en_prev_q, stop_prev_q;
    logic        tick;
    logic        restart;
    logic signed [15:0] ss_level, target;
    logic [15:0] accum, step;

    always_comb
    begin
        tick     = (tick_cnt_q == 32'(TICK_CYCLES - 1));
        ss_level = 16'(cfg_q.base + cfg_q.ss_offset);
        target   = level_select_in
                 ? pick_source(cfg_q.src_two, cfg_q.level_two)
                 : pick_source(cfg_q.src_one, cfg_q.level_one);
        // Carries tenths over ticks so slow rates still advance.
        accum    = 16'(frac_q) + cfg_q.rate;
        step     = accum / RATE_DIV;
        restart  = 1'b0;
        state_d  = state_q;
        level_d  = level_q;
        frac_d   = frac_q;

        if (en_prev_q && !enable_in && state_q != ST_LOCKED)
        begin
            level_d = cfg_q.base;
            state_d = decel_stop_in ? ST_LOCKED : ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (enable_in && !en_prev_q && !decel_stop_in)
                    begin
                        level_d = ss_level;
                        state_d = ST_START;
                        restart = 1'b1;
                        frac_d  = 4'h0;
                    end
                ST_START, ST_RAMP:
                    if (decel_stop_in && !stop_prev_q)
                        state_d = ST_STOP_RAMP;
                    else if (tick)
                    begin
                        state_d = ST_RAMP;
                        if (state_q == ST_RAMP)
                        begin
                            level_d = step_toward(level_q, target, step);
                            frac_d  = 4'(accum % RATE_DIV);
                        end
                    end
                ST_STOP_RAMP:
                    if (level_q == ss_level)
                    begin
                        state_d = ST_STOP_HOLD;
                        restart = 1'b1;
                    end
                    else if (tick)
                    begin
                        level_d = step_toward(level_q, ss_level, step);
                        frac_d  = 4'(accum % RATE_DIV);
                    end
                ST_STOP_HOLD:
                    if (tick)
                    begin
                        level_d = cfg_q.base;
                        state_d = ST_LOCKED;
                    end
                ST_LOCKED:
                    if (!enable_in && !decel_stop_in)
                        state_d = ST_IDLE;
                default:
                begin
                    state_d = ST_IDLE;
                    level_d = cfg_q.base;
                end
            endcase
        end
        if (level_d > cfg_q.ceiling)
            level_d = cfg_q.ceiling;
        tick_cnt_d = (restart || tick) ? 32'h0 : tick_cnt_q + 32'h1;
        active_d   = (state_d != ST_IDLE) && (state_d != ST_LOCKED);
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_q     <= ST_IDLE;
            level_q     <= RST_BASE;
            tick_cnt_q  <= 32'h0;
            frac_q      <= 4'h0;
            active_q    <= 1'b0;
            en_prev_q   <= 1'b0;
            stop_prev_q <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            level_q     <= level_d;
            tick_cnt_q  <= tick_cnt_d;
            frac_q      <= frac_d;
            active_q    <= active_d;
            en_prev_q   <= enable_in;
            stop_prev_q <= decel_stop_in;
        end
    end

    // ------------
    // Output scaling
    // ------------
    // The divider runs continuously; a new result appears 34 to 66 cycles
    // after the level moves, far inside one tick.
    logic        div_busy;
    logic        div_done;
    logic [31:0] div_quot;
    logic signed [16:0] excess;
    logic [31:0] numer;

    always_comb
    begin
        excess   = 17'(level_q) - 17'(cfg_q.base);
        numer    = (excess > 0) ? 32'(excess) * 32'(GAIN_SCALE) : 32'h0;
        scaled_d = scaled_q;
        // Zero at once, without waiting for the divider to catch up.
        if (excess <= 0)
            scaled_d = 16'h0000;
        else if (div_done)
        begin
            if (cfg_q.gain == 16'sd0)
                scaled_d = 16'h0000;
            else if (div_quot > OUT_MAX)
                scaled_d = OUT_MAX[15:0];
            else
                scaled_d = div_quot[15:0];
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            scaled_q <= 16'h0000;
        else
            scaled_q <= scaled_d;
    end

    quotient_unit #(
        .NUM_W (32),
        .DEN_W (16)
    ) u_div (
        .sys_clk_in (sys_clk_in),
        .reset_n_in (reset_n_in),
        .start_in   (!div_busy),
        .num_in     (numer),
        .den_in     (cfg_q.gain),
        .busy_out   (div_busy),
        .done_out   (div_done),
        .quot_out   (div_quot)
    );

    assign wb_dat_out        = rdata_q;
    assign wb_ack_out        = ack_q;
    assign current_level_out = level_q;
    assign scaled_output_out = scaled_q;
    assign ramp_active_out   = active_q;

endmodule : analog_level_ramp

/* testbench/analog_level_ramp_assertions.sv */
module analog_level_ramp_assertions
    import ramp_pkg::*;
#(
    parameter int TICK_CYCLES = 20
)
(
    // Clock and reset
    input  wire logic               sys_clk_in,
    input  wire logic               reset_n_in,
    // Watched ports
    input  wire logic               enable_in,
    input  wire logic               decel_stop_in,
    input  wire logic signed [15:0] current_level_out,
    input  wire logic [15:0]        scaled_output_out,
    input  wire logic               ramp_active_out
);
    logic signed [15:0] lvl_q;
    logic [31:0]        gap_q;
    logic [31:0]        gap_d;

    always_comb
    begin
        gap_d = (current_level_out != lvl_q) ? 32'h0 : gap_q + 32'h1;
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            lvl_q <= 16'sh0;
            gap_q <= 32'h0;
        end
        else
        begin
            lvl_q <= current_level_out;
            gap_q <= gap_d;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_level_held;
        ($stable(current_level_out) || !enable_in) [*8];
    endsequence
    property p_start_hold;
        $rose(ramp_active_out) |=> s_level_held;
    endproperty
    a_start_hold: assert property (p_start_hold)
        else $error("start level not held");
    property p_start_cause;
        $rose(ramp_active_out) |-> $past(enable_in) && !$past(decel_stop_in);
    endproperty
    a_start_cause: assert property (p_start_cause)
        else $error("ramp started without enable");
    property p_en_fall;
        $fell(enable_in) |=> !ramp_active_out;
    endproperty
    a_en_fall: assert property (p_en_fall)
        else $error("ramp kept running after enable fell");
    property p_fall_zero;
        $fell(ramp_active_out) |-> ##[0:60] scaled_output_out == 16'h0000;
    endproperty
    a_fall_zero: assert property (p_fall_zero)
        else $error("output not zero after ramp ended");
    property p_stop_down;
        decel_stop_in && $past(decel_stop_in) && $past(decel_stop_in, 2)
            && ramp_active_out && $past(ramp_active_out)
            |-> current_level_out <= $past(current_level_out);
    endproperty
    a_stop_down: assert property (p_stop_down)
        else $error("level rose during stop");
    property p_stop_refuse;
        decel_stop_in && !ramp_active_out |=> !ramp_active_out;
    endproperty
    a_stop_refuse: assert property (p_stop_refuse)
        else $error("start taken while stop high");
    property p_out_range;
        scaled_output_out <= 16'h7fff;
    endproperty
    a_out_range: assert property (p_out_range)
        else $error("output above range");
    // Start entry and the final drop are excluded: they are not tick steps.
    property p_tick_gap;
        (current_level_out != lvl_q) && ramp_active_out
            && $past(ramp_active_out) |-> gap_q >= TICK_CYCLES - 1;
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("level changed between ticks");
endmodule : analog_level_ramp_assertions

bind analog_level_ramp analog_level_ramp_assertions
    #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.sys_clk_in, .reset_n_in,
    .enable_in, .decel_stop_in, .current_level_out, .scaled_output_out,
    .ramp_active_out);

/* testbench/src_model.sv */
module src_model
    import ramp_pkg::*;
#(
    parameter int NUM_SRC = 4
)
(
    // Values of neighbouring blocks
    output logic [NUM_SRC-1:0][15:0] value_out
);
    // Each block reports a distinct value so a wrong pick shows up.
    always_comb
    begin
        for (int k = 0; k < NUM_SRC; k++)
        begin
            value_out[k] = 16'h0041 + 16'(k) * 16'h000a;
        end
    end
endmodule : src_model

/* testbench/tb_analog_level_ramp.sv */
module tb_analog_level_ramp
    import ramp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICK = 20;
    logic                sys_clk_in;
    logic                reset_n_in;
    logic                wb_cyc_in;
    logic                wb_stb_in;
    logic                wb_we_in;
    logic [7:0]          wb_adr_in;
    logic [3:0]          wb_sel_in;
    logic [31:0]         wb_dat_in;
    logic [31:0]         wb_dat_out;
    logic                wb_ack_out;
    logic                enable_in;
    logic                level_select_in;
    logic                decel_stop_in;
    logic [3:0][15:0]    src_vals;
    logic signed [15:0]  current_level_out;
    logic [15:0]         scaled_output_out;
    logic                ramp_active_out;
    int                  err_total;
    int                  cmp_count;

    analog_level_ramp #(.TICK_CYCLES(TICK), .NUM_SRC(4)) dut_u (
        .sys_clk_in, .reset_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
        .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
        .enable_in, .level_select_in, .decel_stop_in,
        .source_value_in(src_vals), .current_level_out, .scaled_output_out,
        .ramp_active_out);
    src_model #(.NUM_SRC(4)) src_u (.value_out(src_vals));

    always #5 sys_clk_in = ~sys_clk_in;

    // ------------
    // Helpers
    // ------------
    task wrap_up;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    task miss(input string m);
        err_total++;
        $display("MISMATCH %0t %s", $time, m);
    endtask : miss
    task chk16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) miss($sformatf("got %h want %h", got, exp));
    endtask : chk16
    task chk32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) miss($sformatf("reg %h want %h", got, exp));
    endtask : chk32
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in  <= we;
        wb_adr_in <= a;
        wb_sel_in <= 4'hf;
        wb_dat_in <= d;
        @(posedge sys_clk_in);
        while (wb_ack_out !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk_in);
            n++;
        end
        q = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        if (n == 20)
        begin
            miss("bus hang");
            wrap_up;
        end
    endtask : wb
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk32(q, exp);
    endtask : rd
    task ticks(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : ticks
    task nxt(input logic [15:0] want, input logic [15:0] stop_at);
        int n;
        n = 0;
        while (current_level_out !== stop_at && n < 400)
        begin
            @(posedge sys_clk_in);
            n++;
        end
        if (n == 400)
        begin
            miss("level wait ran out");
            wrap_up;
        end
        chk16(current_level_out, want);
    endtask : nxt

    // ------------
    // Scenarios
    // ------------
    task t_regs;
        rd(ADDR_CEILING, 32'h0000_4e20);
        rd(ADDR_RATE, 32'h0000_0001);
        rd(ADDR_GAIN, 32'h0000_0064);
        rd(8'h40, 32'h0000_0000);
        wr(ADDR_RATE, 32'h0000_7fff);
        rd(ADDR_RATE, 32'h0000_2710);
        wr(ADDR_BASE, 32'hffff_b1e0);
        rd(ADDR_BASE, 32'hffff_d8f0);
        wr(ADDR_BASE, 32'h0);
        wr(ADDR_LEVEL_ONE, 32'h64);
        wr(ADDR_LEVEL_TWO, 32'h3c);
        wr(ADDR_SS_OFFSET, 32'h32);
        wr(ADDR_RATE, 32'h64);
        wr(ADDR_CTRL, 32'h3);
    endtask : t_regs
    task t_start;
        enable_in <= 1'b1;
        ticks(2);
        chk16(current_level_out, 16'h0032);
        ticks(TICK - 4);
        chk16(current_level_out, 16'h0032);
        nxt(16'h003c, 16'h003c);
        nxt(16'h0064, 16'h0064);
        ticks(4 * TICK);
        chk16(current_level_out, 16'h0064);
        chk16(scaled_output_out, 16'h0064);
    endtask : t_start
    task t_select;
        level_select_in <= 1'b1;
        nxt(16'h005a, 16'h005a);
        nxt(16'h003c, 16'h003c);
        ticks(2 * TICK);
        chk16(current_level_out, 16'h003c);
    endtask : t_select
    task t_stop;
        decel_stop_in <= 1'b1;
        nxt(16'h0032, 16'h0032);
        nxt(16'h0000, 16'h0000);
        chk16({15'h0, ramp_active_out}, 16'h0000);
        enable_in <= 1'b0;
        ticks(3);
        enable_in <= 1'b1;
        ticks(3);
        chk16(current_level_out, 16'h0000);
        enable_in <= 1'b0;
        decel_stop_in <= 1'b0;
        ticks(3);
        enable_in <= 1'b1;
        ticks(2);
        chk16(current_level_out, 16'h0032);
    endtask : t_stop
    task t_en_fall;
        nxt(16'h003c, 16'h003c);
        enable_in <= 1'b0;
        ticks(2);
        chk16(current_level_out, 16'h0000);
        ticks(60);
        chk16(scaled_output_out, 16'h0000);
    endtask : t_en_fall
    task t_src_ceiling;
        level_select_in <= 1'b0;
        wr(ADDR_CTRL, 32'h10);
        wr(ADDR_CEILING, 32'h46);
        enable_in <= 1'b1;
        nxt(16'h0041, 16'h0041);
        ticks(2 * TICK);
        chk16(current_level_out, 16'h0041);
        wr(ADDR_CTRL, 32'h0);
        nxt(16'h0046, 16'h0046);
        ticks(2 * TICK);
        chk16(current_level_out, 16'h0046);
    endtask : t_src_ceiling

    initial
    begin
        sys_clk_in = 1'b0;
        reset_n_in = 1'b0;
        wb_cyc_in = 1'b0;
        wb_stb_in = 1'b0;
        wb_we_in = 1'b0;
        wb_adr_in = 8'h00;
        wb_sel_in = 4'h0;
        wb_dat_in = 32'h0;
        enable_in = 1'b0;
        level_select_in = 1'b0;
        decel_stop_in = 1'b0;
        err_total = 0;
        cmp_count = 0;
        repeat (8) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        t_regs;
        t_start;
        t_select;
        t_stop;
        t_en_fall;
        t_src_ceiling;
        wrap_up;
    end
endmodule : tb_analog_level_ramp
